// >>> verilog/uart_baud_pkg.sv
// Purpose: shared constants for the serial rate generator and data port
// Assumes: register indices are word indices; byte address = 4 * index
// Notes:   identical layout used by the bus slave and the rate dividers
package uart_baud_pkg;

    // ========================================================
    // bus
    localparam int          ADDR_W      = 12;
    localparam int          DATA_W      = 32;
    localparam int          REG_W       = 8;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ========================================================
    // register indices
    localparam logic [7:0]  IDX_STATUS  = 8'h50;
    localparam logic [7:0]  IDX_DATA    = 8'h51;
    localparam logic [7:0]  IDX_BAUD    = 8'h52;
    localparam logic [7:0]  IDX_CTRL1   = 8'h53;
    localparam logic [7:0]  IDX_CTRL2   = 8'h54;
    localparam logic [7:0]  IDX_RX_EXT  = 8'h55;
    localparam logic [7:0]  IDX_TX_EXT  = 8'h57;

    // ========================================================
    // reset values
    localparam logic [7:0]  BAUD_RST    = 8'h00;
    localparam logic [7:0]  EXT_RST     = 8'h00;
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam logic [7:0]  DATA_RST    = 8'h00;

    // ========================================================
    // fields
    localparam int          COARSE_LSB  = 6;
    localparam int          TX_RATE_LSB = 3;
    localparam int          RX_RATE_LSB = 0;
    localparam int          TX_EMPTY_BIT = 7;
    localparam int          TX_DONE_BIT = 6;
    localparam int          RX_FULL_BIT = 5;

    // ========================================================
    // divider chain
    localparam int          FIXED_DIV   = 16;
    localparam logic [15:0] COARSE_F0   = 16'h0001;
    localparam logic [15:0] COARSE_F1   = 16'h0003;
    localparam logic [15:0] COARSE_F2   = 16'h0004;
    localparam logic [15:0] COARSE_F3   = 16'h000d;

    typedef logic [15:0] period_t;

endpackage

// >>> verilog/rate_divider.sv
// Purpose: one rate clock divider (conventional or extended mode)
// Assumes: configuration fields come from registers on ref_clk
// Notes:   tick is a one-cycle pulse once per period
`timescale 1ns/1ps
module rate_divider (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic [1:0] coarse_code,
    input  wire logic [2:0] rate_code,
    input  wire logic [7:0] ext_value,
    output logic            ext_mode,
    output logic            tick
);
    import uart_baud_pkg::*;

    period_t coarse_f;
    period_t conv_period;
    period_t ext_period;
    period_t period;
    period_t count_reg;
    period_t count_next;
    logic    tick_reg;

    // ========================================================
    // period selection
    always_comb begin
        unique case (coarse_code)
            2'h0: coarse_f = COARSE_F0;
            2'h1: coarse_f = COARSE_F1;
            2'h2: coarse_f = COARSE_F2;
            2'h3: coarse_f = COARSE_F3;
        endcase
    end

    assign conv_period = period_t'(16'(FIXED_DIV) * coarse_f) << rate_code;
    assign ext_period  = 16'(FIXED_DIV) * {8'h00, ext_value};
    assign ext_mode    = (ext_value != EXT_RST);
    assign period      = ext_mode ? ext_period : conv_period;

    // ========================================================
    // counter
    assign count_next = (count_reg == '0) ? period - 16'h0001
                                          : count_reg - 16'h0001;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            count_reg <= '0;
            tick_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick_reg  <= (count_reg == '0);
        end
    end

    assign tick = tick_reg;

    // ========================================================
    // checks
    period_t gap_reg;
    logic    seen_reg;
    logic    same_reg;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            gap_reg  <= '0;
            seen_reg <= 1'b0;
            same_reg <= 1'b0;
        end else begin
            gap_reg  <= tick_reg ? 16'h0001 : gap_reg + 16'h0001;
            seen_reg <= seen_reg | tick_reg;
            same_reg <= (tick_reg | same_reg) & ($past(period) == period);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_tick_spacing: assert property (
        tick_reg && seen_reg && same_reg && $stable(period)
        |-> gap_reg == period)
        else $error("rate tick spacing differs from period");
    a_ext_period: assert property (
        ext_value != 8'h00 |-> period == 16'(ext_value) * 16'h0010)
        else $error("extended period wrong");
    a_coarse_thirteen: assert property (
        ext_value == 8'h00 && coarse_code == 2'h3 && rate_code == 3'h0
        |-> period == 16'h00d0)
        else $error("coarse factor 13 not applied");

endmodule // rate_divider

// >>> verilog/uart_baud_data_port.sv
// Purpose: serial data port, rate generator and register slave
// Assumes: shift registers and frame logic live outside this block
// Notes:   registers sit at byte address 4 * index over AXI4-Lite
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module uart_baud_data_port #(
    parameter int BUF_DEPTH = 2
) (
    input  wire logic                              ref_clk,
    input  wire logic                              reset,
    input  wire logic [uart_baud_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                              s_axi_awvalid,
    output logic                                   s_axi_awready,
    input  wire logic [uart_baud_pkg::DATA_W-1:0]  s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    input  wire logic                              s_axi_wvalid,
    output logic                                   s_axi_wready,
    output logic [1:0]                             s_axi_bresp,
    output logic                                   s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    input  wire logic [uart_baud_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                              s_axi_arvalid,
    output logic                                   s_axi_arready,
    output logic [uart_baud_pkg::DATA_W-1:0]       s_axi_rdata,
    output logic [1:0]                             s_axi_rresp,
    output logic                                   s_axi_rvalid,
    input  wire logic                              s_axi_rready,
    output logic [uart_baud_pkg::REG_W-1:0]        tx_data,
    output logic                                   tx_valid,
    input  wire logic                              tx_ready,
    input  wire logic [uart_baud_pkg::REG_W-1:0]   rx_data,
    input  wire logic                              rx_valid,
    input  wire logic                              tx_frame_done,
    output logic                                   tx_rate_tick,
    output logic                                   rx_rate_tick,
    output logic                                   tx_ext_mode,
    output logic                                   rx_ext_mode,
    output logic [uart_baud_pkg::REG_W-1:0]        control_one,
    output logic [uart_baud_pkg::REG_W-1:0]        control_two
);
    import uart_baud_pkg::*;

    localparam int PTR_W = $clog2(BUF_DEPTH);

    if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_bad_depth
        $error("BUF_DEPTH must be a power of two, at least 2");
    end

    // ========================================================
    // registers
    logic [7:0]        baud_reg;
    logic [7:0]        rx_ext_reg;
    logic [7:0]        tx_ext_reg;
    logic [7:0]        ctrl1_reg;
    logic [7:0]        ctrl2_reg;
    logic [7:0]        rx_holding_reg;
    logic              rx_full_reg;
    logic              tx_done_reg;
    logic              armed_reg;

    // write channel state
    logic              aw_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic              w_held_reg;
    logic [7:0]        wdata_reg;
    logic              wstrb0_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;

    // read channel state
    logic              rvalid_reg;
    logic [1:0]        rresp_reg;
    logic [DATA_W-1:0] rdata_reg;

    // transmit buffer
    logic [7:0]        buf_mem [BUF_DEPTH];
    logic [PTR_W-1:0]  wr_ptr_reg;
    logic [PTR_W-1:0]  rd_ptr_reg;
    logic [PTR_W:0]    count_reg;

    // decode
    logic              wr_ok;
    logic [7:0]        wr_idx;
    logic              wr_mapped;
    logic              wr_go;
    logic              wr_data_hit;
    logic              push;
    logic              pop;
    logic              buf_in_ready;
    logic              rd_go;
    logic              rd_ok;
    logic [7:0]        rd_idx;
    logic              rd_mapped;
    logic [7:0]        rd_value;
    logic              rd_data_hit;
    logic              rd_status_hit;
    logic              rx_clear;
    logic              tx_clear;
    logic              rx_load;

    // ========================================================
    // address decode
    assign wr_ok  = (awaddr_reg[ADDR_W-1:10] == '0)
                    && (awaddr_reg[1:0] == 2'h0);
    assign wr_idx = awaddr_reg[9:2];
    assign rd_ok  = (s_axi_araddr[ADDR_W-1:10] == '0)
                    && (s_axi_araddr[1:0] == 2'h0);
    assign rd_idx = s_axi_araddr[9:2];

    function automatic logic is_mapped(input logic [7:0] idx);
        return idx == IDX_STATUS || idx == IDX_DATA || idx == IDX_BAUD
            || idx == IDX_CTRL1 || idx == IDX_CTRL2
            || idx == IDX_RX_EXT || idx == IDX_TX_EXT;
    endfunction

    assign wr_mapped = wr_ok && is_mapped(wr_idx);
    assign rd_mapped = rd_ok && is_mapped(rd_idx);

    // ========================================================
    // write channel
    assign s_axi_awready = ~aw_held_reg;
    assign s_axi_wready  = ~w_held_reg;
    assign wr_data_hit   = wr_mapped && (wr_idx == IDX_DATA);
    assign buf_in_ready  = (count_reg != (PTR_W+1)'(BUF_DEPTH));
    assign wr_go = aw_held_reg && w_held_reg && !bvalid_reg
                   && (!(wr_data_hit && wstrb0_reg) || buf_in_ready);
    assign push  = wr_go && wr_data_hit && wstrb0_reg;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            aw_held_reg <= 1'b0;
            awaddr_reg  <= '0;
            w_held_reg  <= 1'b0;
            wdata_reg   <= DATA_RST;
            wstrb0_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata[7:0];
                wstrb0_reg <= s_axi_wstrb[0];
            end else if (wr_go) begin
                w_held_reg <= 1'b0;
            end
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    // configuration registers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            baud_reg   <= BAUD_RST;
            rx_ext_reg <= EXT_RST;
            tx_ext_reg <= EXT_RST;
            ctrl1_reg  <= CTRL_RST;
            ctrl2_reg  <= CTRL_RST;
        end else if (wr_go && wr_mapped && wstrb0_reg) begin
            unique case (wr_idx)
                IDX_BAUD:   baud_reg   <= wdata_reg;
                IDX_RX_EXT: rx_ext_reg <= wdata_reg;
                IDX_TX_EXT: tx_ext_reg <= wdata_reg;
                IDX_CTRL1:  ctrl1_reg  <= wdata_reg;
                IDX_CTRL2:  ctrl2_reg  <= wdata_reg;
                default:    ;
            endcase
        end
    end

    assign control_one = ctrl1_reg;
    assign control_two = ctrl2_reg;

    // ========================================================
    // transmit holding buffer
    assign pop      = tx_valid && tx_ready;
    assign tx_valid = (count_reg != '0);
    assign tx_data  = buf_mem[rd_ptr_reg];

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            for (int i = 0; i < BUF_DEPTH; i++) begin
                buf_mem[i] <= DATA_RST;
            end
        end else begin
            if (push) begin
                buf_mem[wr_ptr_reg] <= wdata_reg;
                wr_ptr_reg          <= wr_ptr_reg + PTR_W'(1);
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
            end
            count_reg <= count_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end

    // ========================================================
    // read channel
    assign s_axi_arready = ~rvalid_reg;
    assign rd_go         = s_axi_arvalid && s_axi_arready;
    assign rd_data_hit   = rd_go && rd_mapped && (rd_idx == IDX_DATA);
    assign rd_status_hit = rd_go && rd_mapped && (rd_idx == IDX_STATUS);

    always_comb begin
        rd_value = 8'h00;
        unique case (rd_idx)
            IDX_STATUS: begin
                rd_value[TX_EMPTY_BIT] = buf_in_ready;
                rd_value[TX_DONE_BIT]  = tx_done_reg;
                rd_value[RX_FULL_BIT]  = rx_full_reg;
            end
            IDX_DATA:   rd_value = rx_holding_reg;
            IDX_BAUD:   rd_value = baud_reg;
            IDX_CTRL1:  rd_value = ctrl1_reg;
            IDX_CTRL2:  rd_value = ctrl2_reg;
            IDX_RX_EXT: rd_value = rx_ext_reg;
            IDX_TX_EXT: rd_value = tx_ext_reg;
            default:    rd_value = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= '0;
        end else if (rd_go) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            rdata_reg  <= rd_mapped ? {24'h000000, rd_value} : '0;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp  = rresp_reg;
    assign s_axi_rdata  = rdata_reg;

    // ========================================================
    // receive holding and status flags
    assign rx_clear = rd_data_hit && armed_reg;
    assign tx_clear = push && armed_reg;
    assign rx_load  = rx_valid && (!rx_full_reg || rx_clear);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            armed_reg <= 1'b0;
        end else if (rd_status_hit) begin
            armed_reg <= 1'b1;
        end else if (rd_data_hit || push) begin
            armed_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rx_holding_reg <= DATA_RST;
            rx_full_reg    <= 1'b0;
        end else begin
            if (rx_load) begin
                rx_holding_reg <= rx_data;
            end
            if (rx_valid) begin
                rx_full_reg <= 1'b1;
            end else if (rx_clear) begin
                rx_full_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tx_done_reg <= 1'b1;
        end else if (tx_frame_done) begin
            tx_done_reg <= 1'b1;
        end else if (tx_clear) begin
            tx_done_reg <= 1'b0;
        end
    end

    // ========================================================
    // rate generators
    rate_divider tx_div (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .coarse_code (baud_reg[COARSE_LSB +: 2]),
        .rate_code   (baud_reg[TX_RATE_LSB +: 3]),
        .ext_value   (tx_ext_reg),
        .ext_mode    (tx_ext_mode),
        .tick        (tx_rate_tick)
    );

    rate_divider rx_div (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .coarse_code (baud_reg[COARSE_LSB +: 2]),
        .rate_code   (baud_reg[RX_RATE_LSB +: 3]),
        .ext_value   (rx_ext_reg),
        .ext_mode    (rx_ext_mode),
        .tick        (rx_rate_tick)
    );

    // ========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_rx_load_data: assert property (
        rx_load |=> rx_holding_reg == $past(rx_data) && rx_full_reg)
        else $error("received word not loaded");
    a_data_read_value: assert property (
        rd_data_hit && !rx_load
        |=> s_axi_rvalid && s_axi_rdata == {24'h0, $past(rx_holding_reg)})
        else $error("data read not from receive holding");
    a_data_write_push: assert property (
        push && !pop |=> count_reg == $past(count_reg) + 1'b1
        ##0 tx_valid)
        else $error("data write not queued");
    a_rx_flag_clear: assert property (
        rx_clear && !rx_valid |=> !rx_full_reg)
        else $error("receive flag not cleared by sequence");
    a_rx_flag_kept: assert property (
        rd_data_hit && !armed_reg && rx_full_reg |=> rx_full_reg)
        else $error("receive flag cleared without status access");
    a_tx_done_clear: assert property (
        tx_clear && !tx_frame_done |=> !tx_done_reg)
        else $error("done flag not cleared by sequence");
    a_reset_zero: assert property (
        $fell(reset) |-> baud_reg == 8'h00 && rx_ext_reg == 8'h00
        && tx_ext_reg == 8'h00 && !tx_ext_mode && !rx_ext_mode)
        else $error("divider registers not zero after reset");
    a_conv_tx_rate: assert property (
        $rose(tx_rate_tick) && baud_reg == 8'h00 && tx_ext_reg == 8'h00
        |=> !tx_rate_tick [*8] ##1 !tx_rate_tick [*7] ##1 tx_rate_tick)
        else $error("transmit rate not sixteen cycles at unity");

    c_write_push:  cover property (push ##[1:20] pop);
    c_buffer_full: cover property (count_reg == (PTR_W+1)'(BUF_DEPTH));
    c_rx_sequence: cover property (rd_status_hit ##[1:20] rx_clear);
    c_ext_tick:    cover property (rx_ext_mode && rx_rate_tick);

endmodule // uart_baud_data_port

// >>> testbench/serial_far_end.sv
// Purpose: far-end serial transceiver model
// Assumes: bench commands receive words and frame completion
// Notes:   slow mode stalls the transmit stream
`timescale 1ns/1ps
module serial_far_end (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       slow,
    input  wire logic       frame_en,
    input  wire logic       send,
    input  wire logic [7:0] send_byte,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic            tx_frame_done,
    output logic [7:0]      rx_data,
    output logic            rx_valid
);
    logic [2:0] cnt_reg;
    // ====================================================
    // transmit side takes words, sometimes slowly
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cnt_reg       <= 3'h0;
            tx_ready      <= 1'b0;
            tx_frame_done <= 1'b0;
        end else begin
            cnt_reg       <= cnt_reg + 3'h1;
            tx_ready      <= !slow || cnt_reg == 3'h0;
            tx_frame_done <= frame_en && tx_valid && tx_ready;
        end
    end
    // ====================================================
    // receive side, data line not held outside the pulse
    always_ff @(posedge ref_clk) begin
        rx_valid <= send && !reset;
        rx_data  <= reset ? 8'h5a : send ? send_byte : ~rx_data;
    end
endmodule // serial_far_end

// >>> testbench/uart_baud_data_port_tb.sv
// Purpose: self-checking bench for the rate generator and data port
// Assumes: partner model stands for the far serial end
// Notes:   bus responses and transmit words are queued and checked by monitors; rates are checked in line
`timescale 1ns/1ps
module uart_baud_data_port_tb;
    import uart_baud_pkg::*;
    logic        ref_clk = 1'b0, reset = 1'b1, slow = 1'b0, frame_en = 1'b1;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, seed = 32'h78fc8dc3;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic        rready = 1'b0, send = 1'b0, awready, wready, bvalid, arready;
    logic        rvalid, tx_valid, tx_ready, rx_valid, fdone, txt, rxt;
    logic        txe, rxe;
    logic [1:0]  bresp, rresp;
    logic [7:0]  tx_data, rx_data, ctl1, ctl2, b, e, send_byte = '0;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    logic [7:0]  tq[$];
    int          fac[4] = '{COARSE_F0, COARSE_F1, COARSE_F2, COARSE_F3};
    int          fail_count = 0, n_checks = 0, cyc = 0;
    uart_baud_data_port i_uart_baud_data_port (.ref_clk, .reset,
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_data, .tx_valid,
        .tx_ready, .rx_data, .rx_valid, .tx_frame_done(fdone),
        .tx_rate_tick(txt), .rx_rate_tick(rxt), .tx_ext_mode(txe),
        .rx_ext_mode(rxe), .control_one(ctl1), .control_two(ctl2));
    serial_far_end i_serial_far_end (.ref_clk, .reset, .slow, .frame_en,
        .send, .send_byte, .tx_valid, .tx_ready, .tx_frame_done(fdone),
        .rx_data, .rx_valid);
    always #2.5 ref_clk = ~ref_clk;
    // ====================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d,
                      input logic [1:0] r = RESP_OKAY);
        logic ta, tw, tb;
        @(posedge ref_clk);
        awaddr <= {2'b00, i, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        bq.push_back(r);
        if (i == IDX_DATA && r == RESP_OKAY) tq.push_back(d);
        for (int n = 0; n < 9000; n++) begin
            @(negedge ref_clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            @(posedge ref_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                return;
            end
        end
        fail_count++;
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] d,
                      input logic [1:0] r = RESP_OKAY);
        logic ta, tr;
        @(posedge ref_clk);
        araddr <= {2'b00, i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        rq.push_back({r, 24'h0, d});
        for (int n = 0; n < 9000; n++) begin
            @(negedge ref_clk);
            ta = arvalid && arready;
            tr = rvalid;
            @(posedge ref_clk);
            if (ta) arvalid <= 1'b0;
            if (tr) begin
                rready <= 1'b0;
                return;
            end
        end
        fail_count++;
    endtask
    task automatic meas(input logic rx_sel, input int exp);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while ((rx_sel ? rxt : txt) !== 1'b1 && n < 5000);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while ((rx_sel ? rxt : txt) !== 1'b1 && n < 5000);
        check(n, exp);
        @(posedge ref_clk);
    endtask
    task automatic drain();
        for (int n = 0; n < 2000 && tq.size() != 0; n++) @(posedge ref_clk);
        repeat (3) @(posedge ref_clk);
        check(tq.size(), 0);
    endtask
    // ====================================================
    // monitors and timeout
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    always @(posedge ref_clk) begin
        if (bvalid && bready) check(bresp, bq.pop_front());
        if (rvalid && rready) check({rresp, rdata}, rq.pop_front());
        if (tx_valid && tx_ready) check(tx_data, tq.pop_front());
    end
    // ====================================================
    // scenarios
    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rd(IDX_BAUD, 8'h00);
        rd(IDX_RX_EXT, 8'h00);
        rd(IDX_TX_EXT, 8'h00);
        rd(IDX_STATUS, 8'hc0);
        for (int c = 0; c < 4; c++) begin
            seed = xs(seed);
            b = {c[1:0], c == 0 && seed[4], seed[1:0],
                 c == 0 && seed[5], seed[3:2]};
            wr(IDX_BAUD, b);
            rd(IDX_BAUD, b);
            meas(0, (16 * fac[c]) << b[5:3]);
            meas(1, (16 * fac[c]) << b[2:0]);
        end
        seed = xs(seed);
        e = {4'h0, seed[3:0]} | 8'h01;
        wr(IDX_RX_EXT, e);
        wr(IDX_TX_EXT, 8'hff);
        check({rxe, txe}, 2'b11);
        meas(1, 16 * e);
        meas(0, 16 * 255);
        wr(IDX_TX_EXT, 8'h00);
        check(txe, 1'b0);
        wr(IDX_CTRL1, seed[15:8]);
        wr(IDX_CTRL2, seed[31:24]);
        check({ctl1, ctl2}, {seed[15:8], seed[31:24]});
        slow <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            seed = xs(seed);
            wr(IDX_DATA, seed[7:0]);
        end
        drain();
        slow <= 1'b0;
        frame_en <= 1'b0;
        rd(IDX_STATUS, 8'hc0);
        wr(IDX_DATA, 8'h3c);
        drain();
        rd(IDX_STATUS, 8'h80);
        send_byte <= seed[23:16];
        send <= 1'b1;
        @(posedge ref_clk);
        send <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rd(IDX_STATUS, 8'ha0);
        rd(IDX_DATA, seed[23:16]);
        rd(IDX_STATUS, 8'h80);
        rd(8'h56, 8'h00, RESP_SLVERR);
        wr(8'h56, 8'h12, RESP_SLVERR);
        tally_and_finish();
    end
endmodule // uart_baud_data_port_tb
